// [logic/feature_sync_defs.svh]
// Register offsets, field positions and reset values of the feature and sync register slice.
`ifndef FEATURE_SYNC_DEFS_SVH
`define FEATURE_SYNC_DEFS_SVH
`define ADDR_PATTERN_ONE_LOW    13'h0019
`define ADDR_PATTERN_ONE_HIGH   13'h001A
`define ADDR_PATTERN_TWO_LOW    13'h001B
`define ADDR_PATTERN_TWO_HIGH   13'h001C
`define ADDR_SIGNATURE_LOW      13'h0024
`define ADDR_FEATURE_SELECT     13'h002A
`define ADDR_OUTPUT_ASSIGN      13'h002E
`define ADDR_SYNC_CONTROL       13'h0100
`define ADDR_MISC_USER_CONTROL  13'h0101
`define RST_PATTERN_BYTE        8'h00
`define RST_FEATURE_SELECT      8'h01
`define RST_ASSIGN_CH_A         8'h00
`define RST_ASSIGN_CH_B         8'h01
`define RST_SYNC_CONTROL        8'h01
`define RST_MISC_USER_CONTROL   8'h88
`define SYNC_MASTER_BIT         0
`define SYNC_DIVIDER_BIT        1
`define SYNC_FIRST_ONLY_BIT     2
`define MISC_OE_PIN_BIT         7
`define MISC_OSC_DETECT_BIT     3
`define MISC_OSC_RUN_BIT        2
`define MISC_PULLDOWN_OFF_BIT   0
`define SPI_INSTR_BITS          5'd16
`define SPI_FRAME_BITS          5'd24
`define SPI_READ_BIT            15
`endif

// [logic/feature_sync_pkg.sv]
// Types shared by the feature and sync register slice.
package feature_sync_pkg;
  typedef enum logic [1:0] {
    PH_INSTR,
    PH_DATA,
    PH_DONE
  } spi_phase_e;
  typedef logic [7:0] reg_byte_t;
endpackage

// [logic/adc_feature_sync_registers.sv]
// Serial-port register slice: user patterns, signature, per-channel features, sync gating and misc control.
`timescale 1ns/1ps
`include "feature_sync_defs.svh"
module adc_feature_sync_registers (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  // Serial port pins
  input  wire logic                      sclk,
  input  wire logic                      csb,
  input  wire logic                      sdio_in,
  output logic                           sdio_out,
  output logic                           sdio_oe,
  output logic                           sdio_pulldown_enable,
  // Channel index from the index register
  input  wire logic                      channel_index_a,
  input  wire logic                      channel_index_b,
  // Self-test result
  input  wire feature_sync_pkg::reg_byte_t self_test_signature_low,
  // User pattern and per-channel configuration outputs
  output logic [15:0]                    user_pattern_one,
  output logic [15:0]                    user_pattern_two,
  output logic [1:0]                     over_range_enable,
  output logic                           output_assign_a,
  output logic                           output_assign_b,
  // Sync path
  input  wire logic                      sync_pin,
  output logic                           divider_sync_pulse,
  // Output enable pin and low-rate oscillator
  input  wire logic                      output_enable_pin_bar,
  input  wire logic                      low_rate_detected,
  output logic [1:0]                     data_outputs_enabled,
  output logic                           low_rate_internal_oscillator
);
  import feature_sync_pkg::*;

  // Reset bytes held as typed constants so that single bits can be picked out of them.
  localparam reg_byte_t FEATURE_RST  = `RST_FEATURE_SELECT;
  localparam reg_byte_t ASSIGN_A_RST = `RST_ASSIGN_CH_A;
  localparam reg_byte_t ASSIGN_B_RST = `RST_ASSIGN_CH_B;
  localparam reg_byte_t MISC_RST     = `RST_MISC_USER_CONTROL;

  reg_byte_t  pat_one_low_reg;
  reg_byte_t  pat_one_high_reg;
  reg_byte_t  pat_two_low_reg;
  reg_byte_t  pat_two_high_reg;
  logic [1:0] or_oe_reg;
  logic [1:0] assign_reg;
  reg_byte_t  sync_ctrl_reg;
  reg_byte_t  misc_reg;
  logic [1:0] oe_pin_en_reg;

  // Three-stage synchronisers; a level counts once stages two and three agree.
  logic [2:0] sclk_sr;
  logic [2:0] csb_sr;
  logic [2:0] sdio_sr;
  logic [2:0] sync_sr;
  logic [2:0] oe_pin_sr;
  logic       sclk_lvl_reg;
  logic       csb_lvl_reg;
  logic       sdio_lvl_reg;
  logic       sync_lvl_reg;
  logic       oe_pin_lvl_reg;

  spi_phase_e phase_reg;
  logic [4:0] bit_cnt_reg;
  logic [15:0] instr_reg;
  reg_byte_t  wdata_reg;
  reg_byte_t  rshift_reg;
  logic       sdio_out_reg;

  logic       sclk_rise;
  logic       sclk_fall;
  logic       sync_rise;
  logic       is_read;
  logic [12:0] addr;
  logic       write_strobe;
  reg_byte_t  rdata;
  logic       divider_sync;

  function automatic logic filt(input logic [2:0] sr, input logic lvl);
    filt = (sr[1] == sr[2]) ? sr[2] : lvl;
  endfunction

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclk_sr <= 3'h0;
      csb_sr  <= 3'h7;
      sdio_sr <= 3'h0;
      sync_sr <= 3'h0;
      // The enable pin starts as inactive, so the data outputs stay off until it is seen low or a channel's enable-pin bit is cleared.
      oe_pin_sr <= 3'h7;
      sclk_lvl_reg <= 1'b0;
      csb_lvl_reg  <= 1'b1;
      sdio_lvl_reg <= 1'b0;
      sync_lvl_reg <= 1'b0;
      oe_pin_lvl_reg <= 1'b1;
    end else begin
      sclk_sr <= {sclk_sr[1:0], sclk};
      csb_sr  <= {csb_sr[1:0], csb};
      sdio_sr <= {sdio_sr[1:0], sdio_in};
      sync_sr <= {sync_sr[1:0], sync_pin};
      oe_pin_sr <= {oe_pin_sr[1:0], output_enable_pin_bar};
      sclk_lvl_reg <= filt(sclk_sr, sclk_lvl_reg);
      csb_lvl_reg  <= filt(csb_sr, csb_lvl_reg);
      sdio_lvl_reg <= filt(sdio_sr, sdio_lvl_reg);
      sync_lvl_reg <= filt(sync_sr, sync_lvl_reg);
      oe_pin_lvl_reg <= filt(oe_pin_sr, oe_pin_lvl_reg);
    end
  end

  assign sclk_rise = ~csb_lvl_reg & ~sclk_lvl_reg & filt(sclk_sr, sclk_lvl_reg);
  assign sclk_fall = ~csb_lvl_reg & sclk_lvl_reg & ~filt(sclk_sr, sclk_lvl_reg);
  assign sync_rise = ~sync_lvl_reg & filt(sync_sr, sync_lvl_reg);
  assign is_read   = instr_reg[`SPI_READ_BIT];
  assign addr      = instr_reg[12:0];

  // The last data bit enters the shifter on the same edge, so the write waits one cycle for it.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      write_strobe <= 1'b0;
    end else begin
      write_strobe <= sclk_rise & (phase_reg == PH_DATA) & ~is_read &
                      (bit_cnt_reg == `SPI_FRAME_BITS - 5'd1);
    end
  end

  // Serial frame: 16 instruction bits then one data byte, MSB first, sampled on rising clock.
  // Streaming beyond one byte is not supported; extra clocks are ignored until chip select rises.
  always_ff @(posedge clk) begin
    if (sys_rst || csb_lvl_reg) begin
      phase_reg   <= PH_INSTR;
      bit_cnt_reg <= 5'd0;
    end else if (sclk_rise) begin
      if (phase_reg != PH_DONE) begin
        bit_cnt_reg <= bit_cnt_reg + 5'd1;
      end
      if (phase_reg == PH_INSTR && bit_cnt_reg == `SPI_INSTR_BITS - 5'd1) begin
        phase_reg <= PH_DATA;
      end else if (phase_reg == PH_DATA && bit_cnt_reg == `SPI_FRAME_BITS - 5'd1) begin
        phase_reg <= PH_DONE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      instr_reg <= 16'h0000;
      wdata_reg <= 8'h00;
    end else if (sclk_rise && phase_reg == PH_INSTR) begin
      instr_reg <= {instr_reg[14:0], sdio_lvl_reg};
    end else if (sclk_rise && phase_reg == PH_DATA) begin
      wdata_reg <= {wdata_reg[6:0], sdio_lvl_reg};
    end
  end

  // Read data is shifted out on falling clock edges during the data phase.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rshift_reg   <= 8'h00;
      sdio_out_reg <= 1'b0;
    end else if (sclk_rise && phase_reg == PH_INSTR && bit_cnt_reg == `SPI_INSTR_BITS - 5'd1) begin
      rshift_reg <= rdata;
    end else if (sclk_fall && phase_reg == PH_DATA && is_read) begin
      sdio_out_reg <= rshift_reg[7];
      rshift_reg   <= {rshift_reg[6:0], 1'b0};
    end
  end

  assign sdio_out = sdio_out_reg;
  // The pin is driven from the first data fall, the edge that puts bit 7 out.
  assign sdio_oe  = ~csb_lvl_reg & is_read & (phase_reg == PH_DATA) &
                    ((bit_cnt_reg != `SPI_INSTR_BITS) | ~sclk_lvl_reg);

  // The address is complete only after the sixteenth bit, so the read mux uses the shifted-in value.
  always_comb begin
    logic [12:0] ra;
    ra = {instr_reg[11:0], sdio_lvl_reg};
    rdata = 8'h00;
    case (ra)
      `ADDR_PATTERN_ONE_LOW:   rdata = pat_one_low_reg;
      `ADDR_PATTERN_ONE_HIGH:  rdata = pat_one_high_reg;
      `ADDR_PATTERN_TWO_LOW:   rdata = pat_two_low_reg;
      `ADDR_PATTERN_TWO_HIGH:  rdata = pat_two_high_reg;
      `ADDR_SIGNATURE_LOW:     rdata = self_test_signature_low;
      `ADDR_FEATURE_SELECT:    rdata = {7'h00, channel_index_a ? or_oe_reg[0] : or_oe_reg[1]};
      `ADDR_OUTPUT_ASSIGN:     rdata = {7'h00, channel_index_a ? assign_reg[0] : assign_reg[1]};
      `ADDR_SYNC_CONTROL:      rdata = {5'h00, sync_ctrl_reg[2:0]};
      `ADDR_MISC_USER_CONTROL: rdata = {channel_index_a ? oe_pin_en_reg[0] : oe_pin_en_reg[1],
                                        3'h0, misc_reg[3:2], 1'b0, misc_reg[0]};
      default:                 rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pat_one_low_reg  <= `RST_PATTERN_BYTE;
      pat_one_high_reg <= `RST_PATTERN_BYTE;
      pat_two_low_reg  <= `RST_PATTERN_BYTE;
      pat_two_high_reg <= `RST_PATTERN_BYTE;
    end else if (write_strobe) begin
      if (addr == `ADDR_PATTERN_ONE_LOW)  pat_one_low_reg  <= wdata_reg;
      if (addr == `ADDR_PATTERN_ONE_HIGH) pat_one_high_reg <= wdata_reg;
      if (addr == `ADDR_PATTERN_TWO_LOW)  pat_two_low_reg  <= wdata_reg;
      if (addr == `ADDR_PATTERN_TWO_HIGH) pat_two_high_reg <= wdata_reg;
    end
  end

  // Local registers: a write lands in every channel whose index bit is set.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      or_oe_reg     <= {2{FEATURE_RST[0]}};
      assign_reg    <= {ASSIGN_B_RST[0], ASSIGN_A_RST[0]};
      oe_pin_en_reg <= {2{MISC_RST[`MISC_OE_PIN_BIT]}};
    end else if (write_strobe) begin
      if (addr == `ADDR_FEATURE_SELECT) begin
        if (channel_index_a) or_oe_reg[0] <= wdata_reg[0];
        if (channel_index_b) or_oe_reg[1] <= wdata_reg[0];
      end
      if (addr == `ADDR_OUTPUT_ASSIGN) begin
        if (channel_index_a) assign_reg[0] <= wdata_reg[0];
        if (channel_index_b) assign_reg[1] <= wdata_reg[0];
      end
      if (addr == `ADDR_MISC_USER_CONTROL) begin
        if (channel_index_a) oe_pin_en_reg[0] <= wdata_reg[`MISC_OE_PIN_BIT];
        if (channel_index_b) oe_pin_en_reg[1] <= wdata_reg[`MISC_OE_PIN_BIT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      misc_reg <= `RST_MISC_USER_CONTROL;
    end else if (write_strobe && addr == `ADDR_MISC_USER_CONTROL) begin
      misc_reg <= {1'b0, 3'h0, wdata_reg[3:2], 1'b0, wdata_reg[0]};
    end
  end

  // Divider sync fires only with master and divider enables both set.
  assign divider_sync = sync_rise & sync_ctrl_reg[`SYNC_MASTER_BIT] & sync_ctrl_reg[`SYNC_DIVIDER_BIT];

  // A host write in the same cycle as the self-clear wins, so a re-arm is never lost.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_ctrl_reg <= `RST_SYNC_CONTROL;
    end else if (write_strobe && addr == `ADDR_SYNC_CONTROL) begin
      sync_ctrl_reg <= {5'h00, wdata_reg[2:0]};
    end else if (divider_sync && sync_ctrl_reg[`SYNC_FIRST_ONLY_BIT]) begin
      sync_ctrl_reg[`SYNC_DIVIDER_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      divider_sync_pulse <= 1'b0;
    end else begin
      divider_sync_pulse <= divider_sync;
    end
  end

  assign user_pattern_one  = {pat_one_high_reg, pat_one_low_reg};
  assign user_pattern_two  = {pat_two_high_reg, pat_two_low_reg};
  assign over_range_enable = or_oe_reg;
  assign output_assign_a   = assign_reg[0];
  assign output_assign_b   = assign_reg[1];
  assign data_outputs_enabled = ~oe_pin_en_reg | {2{~oe_pin_lvl_reg}};
  assign low_rate_internal_oscillator = misc_reg[`MISC_OSC_RUN_BIT] |
                                        (misc_reg[`MISC_OSC_DETECT_BIT] & low_rate_detected);
  assign sdio_pulldown_enable = ~misc_reg[`MISC_PULLDOWN_OFF_BIT];
endmodule

// [dv/adc_feature_sync_sva.sv]
// Port assertions for the feature and sync register slice.
`timescale 1ns/1ps
module adc_feature_sync_checker (
  // Clock, reset and pins
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        csb,
  input wire logic        sdio_oe,
  input wire logic        sdio_pulldown_enable,
  input wire logic        sync_pin,
  input wire logic        divider_sync_pulse,
  input wire logic        output_enable_pin_bar,
  input wire logic        low_rate_detected,
  input wire logic        low_rate_internal_oscillator,
  // Configuration outputs
  input wire logic [15:0] user_pattern_one,
  input wire logic [15:0] user_pattern_two,
  input wire logic [1:0]  over_range_enable,
  input wire logic        output_assign_a,
  input wire logic        output_assign_b,
  input wire logic [1:0]  data_outputs_enabled
);
  default clocking @(posedge clk); endclocking
  logic [8:0] since_rst_reg;
  // No frame can finish within 300 cycles of reset, so sync must stay off until then.
  always_ff @(posedge clk) begin
    if (sys_rst) since_rst_reg <= 9'h000;
    else if (since_rst_reg != 9'h1FF) since_rst_reg <= since_rst_reg + 9'h001;
  end
  a_reset_patterns: assert property (sys_rst |=> user_pattern_one == 16'h0000 && user_pattern_two == 16'h0000)
    else $error("patterns not cleared by reset");
  a_reset_channel_cfg: assert property (sys_rst |=> over_range_enable == 2'b11 && !output_assign_a && output_assign_b)
    else $error("channel config wrong after reset");
  a_reset_misc_ctrl: assert property (sys_rst ##1 sys_rst |-> sdio_pulldown_enable
    && low_rate_internal_oscillator == low_rate_detected) else $error("misc control wrong after reset");
  a_sync_off_start: assert property (disable iff (sys_rst) since_rst_reg < 9'd300 |-> !divider_sync_pulse)
    else $error("sync pulse with divider sync disabled");
  a_pulse_has_edge: assert property (disable iff (sys_rst) divider_sync_pulse |-> $past(sync_pin, 2) && !$past(sync_pin, 8))
    else $error("sync pulse without pin edge");
  a_pulse_one_cycle: assert property (disable iff (sys_rst) divider_sync_pulse |=> !divider_sync_pulse)
    else $error("sync pulse longer than one cycle");
  a_oe_pin_low: assert property (disable iff (sys_rst) !output_enable_pin_bar [*6] |-> data_outputs_enabled == 2'b11)
    else $error("outputs off with enable pin low");
  a_oe_pin_high: assert property (output_enable_pin_bar [*6] ##0 sys_rst |=> data_outputs_enabled == 2'b00)
    else $error("outputs on with enable pin high");
  a_sdio_quiet: assert property (disable iff (sys_rst) csb [*6] |-> !sdio_oe)
    else $error("data pin driven outside frame");
  a_cfg_held: assert property (disable iff (sys_rst) csb [*8] |-> $stable(user_pattern_one)
    && $stable(user_pattern_two) && $stable(over_range_enable)) else $error("config changed outside frame");
  c_sync_pulse: cover property (divider_sync_pulse);
  c_read_phase: cover property (sdio_oe);
  c_one_ignored: cover property (data_outputs_enabled == 2'b10);
endmodule
bind adc_feature_sync_registers adc_feature_sync_checker u_chk (.clk(clk), .sys_rst(sys_rst), .csb(csb),
  .sdio_oe(sdio_oe), .sdio_pulldown_enable(sdio_pulldown_enable), .sync_pin(sync_pin),
  .divider_sync_pulse(divider_sync_pulse), .output_enable_pin_bar(output_enable_pin_bar),
  .low_rate_detected(low_rate_detected), .low_rate_internal_oscillator(low_rate_internal_oscillator),
  .user_pattern_one(user_pattern_one), .user_pattern_two(user_pattern_two), .over_range_enable(over_range_enable),
  .output_assign_a(output_assign_a), .output_assign_b(output_assign_b), .data_outputs_enabled(data_outputs_enabled));

// [dv/spi_host_model.sv]
// Serial host model that drives framed register accesses.
`timescale 1ns/1ps
module spi_host_model (
  // Clock
  input wire logic clk,
  // Serial port
  output logic     sclk,
  output logic     csb,
  output logic     sdio_in,
  input wire logic sdio_out,
  // Line state when the device lets go
  input wire logic sdio_oe,
  input wire logic sdio_pd_en
);
  initial begin
    sclk = 1'b0;
    csb = 1'b1;
    sdio_in = 1'b0;
  end
  // Half periods of 8 clocks give the 3-flop synchronisers margin over their 4-clock minimum.
  task automatic xfer(input logic rd, input logic [12:0] addr, input logic [7:0] wd, output logic [7:0] rdat);
    logic [23:0] frame;
    frame = {rd, 2'b00, addr, wd};
    rdat = 8'h00;
    @(posedge clk) csb <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 23; i >= 0; i--) begin
      // During read data the host has let go, so the line wanders instead of holding a stale level.
      sdio_in <= (rd && i < 8) ? ~sdio_in : frame[i];
      repeat (8) @(posedge clk);
      // A released line falls to the pull-down, or shows the opposite level when that is off.
      if (i < 8) rdat[i] = sdio_oe ? sdio_out : (sdio_pd_en ? 1'b0 : ~sdio_out);
      sclk <= 1'b1;
      repeat (8) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (8) @(posedge clk);
    csb <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
endmodule

// [dv/adc_feature_sync_registers_tb_top.sv]
// Self-checking testbench for the feature and sync register slice.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; $display("BAD t=%0t got=%0h exp=%0h", $time, g, e); end end
module adc_feature_sync_registers_tb_top;
  logic        clk, sys_rst, sclk, csb, sdio_in, sdio_out, sdio_oe, pd_en, idx_a, idx_b;
  logic        sync_pin, oe_pin_bar, lr_det, osc, dsp, asg_a, asg_b;
  logic [15:0] pat1, pat2;
  logic [1:0]  ore, doe;
  logic [7:0]  sig, rd;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          pulses = 0;
  typedef struct { logic [12:0] a; logic [7:0] w; logic [7:0] r; } row_s;
  row_s rows[9] = '{'{13'h0019, 8'hA5, 8'hA5}, '{13'h001A, 8'h3C, 8'h3C}, '{13'h001B, 8'h96, 8'h96},
    '{13'h001C, 8'hE1, 8'hE1}, '{13'h0024, 8'h5A, 8'hC3}, '{13'h0030, 8'hFF, 8'h00},
    '{13'h002A, 8'hFE, 8'h00}, '{13'h002E, 8'hFF, 8'h01}, '{13'h0101, 8'hF5, 8'h85}};
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (dsp === 1'b1) pulses++;
  adc_feature_sync_registers u_dut (.clk(clk), .sys_rst(sys_rst), .sclk(sclk), .csb(csb), .sdio_in(sdio_in),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sdio_pulldown_enable(pd_en), .channel_index_a(idx_a),
    .channel_index_b(idx_b), .self_test_signature_low(sig), .user_pattern_one(pat1), .user_pattern_two(pat2),
    .over_range_enable(ore), .output_assign_a(asg_a), .output_assign_b(asg_b), .sync_pin(sync_pin),
    .divider_sync_pulse(dsp), .output_enable_pin_bar(oe_pin_bar), .low_rate_detected(lr_det),
    .data_outputs_enabled(doe), .low_rate_internal_oscillator(osc));
  spi_host_model u_host (.clk(clk), .sclk(sclk), .csb(csb), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .sdio_pd_en(pd_en));
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    u_host.xfer(1'b0, a, d, rd);
  endtask
  task automatic rdr(input logic [12:0] a);
    u_host.xfer(1'b1, a, 8'h00, rd);
  endtask
  task automatic pulse();
    sync_pin <= 1'b1;
    repeat (12) @(posedge clk);
    sync_pin <= 1'b0;
    repeat (12) @(posedge clk);
  endtask
  task automatic give_verdict();
    $display("miscompares %0d of cmp_count %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    give_verdict();
  end
  initial begin
    sys_rst = 1'b1;
    idx_a = 1'b1;
    idx_b = 1'b0;
    sig = 8'hC3;
    sync_pin = 1'b0;
    oe_pin_bar = 1'b1;
    lr_det = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    `CHK({pat1, pat2}, 32'h0000_0000);
    `CHK({ore, asg_a, asg_b}, 4'hD);
    `CHK({pd_en, osc}, 2'b11);
    @(posedge clk) sys_rst <= 1'b0;
    pulse();
    `CHK(pulses, 0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rdr(rows[i].a);
      `CHK(rd, rows[i].r);
    end
    #1;
    `CHK({pat1, pat2}, 32'h3CA5_E196);
    `CHK(ore, 2'b10);
    `CHK({asg_a, asg_b, pd_en, osc}, 4'hD);
    @(posedge clk) idx_a <= 1'b0;
    idx_b <= 1'b1;
    wr(13'h002A, 8'h00);
    wr(13'h002E, 8'h00);
    wr(13'h0101, 8'h08);
    rdr(13'h0101);
    `CHK(rd, 8'h08);
    `CHK({ore, asg_b, doe, osc}, 6'h05);
    oe_pin_bar <= 1'b0;
    lr_det <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    `CHK({doe, osc}, 3'h6);
    wr(13'h0101, 8'h00);
    lr_det <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK({pd_en, osc}, 2'b10);
    wr(13'h0100, 8'h02);
    pulse();
    `CHK(pulses, 0);
    wr(13'h0100, 8'h03);
    pulse();
    pulse();
    `CHK(pulses, 2);
    wr(13'h0100, 8'h07);
    pulse();
    pulse();
    `CHK(pulses, 3);
    rdr(13'h0100);
    `CHK(rd, 8'h05);
    // A second reset after every register was changed must bring each one back.
    sys_rst <= 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    `CHK({pat1, pat2, ore, asg_a, asg_b}, 36'h0_0000_000D);
    `CHK({pd_en, osc}, 2'h3);
    repeat (4) @(posedge clk);
    rdr(13'h0100);
    `CHK(rd, 8'h01);
    rdr(13'h0101);
    `CHK(rd, 8'h88);
    give_verdict();
  end
endmodule
